// [rtl/mouse_link_pkg.sv]
package mouse_link_pkg;

  localparam int unsigned SYS_CLK_MHZ      = 200;
  localparam int unsigned INHIBIT_TIME_US  = 100;
  localparam int unsigned RESPONSE_TIME_MS = 10;
  localparam int unsigned RX_GAP_TIME_MS   = 2;

  // Least time rounds up, longest time rounds down; both are exact here
  localparam int unsigned INHIBIT_CYC_DEF  =
    (INHIBIT_TIME_US * SYS_CLK_MHZ * 1000 + 999) / 1000;
  localparam int unsigned RESPONSE_CYC_DEF =
    RESPONSE_TIME_MS * 1000 * SYS_CLK_MHZ;
  localparam int unsigned RX_GAP_CYC_DEF   =
    RX_GAP_TIME_MS * 1000 * SYS_CLK_MHZ;

  localparam int unsigned SLICE_BITS = 11;
  localparam int unsigned SLICES     = 3;
  localparam int unsigned FRAME_BITS = SLICE_BITS * SLICES;
  localparam int unsigned START_POS  = 0;
  localparam int unsigned DATA_POS   = 1;
  localparam int unsigned PAR_POS    = 9;
  localparam int unsigned STOP_POS   = 10;
  localparam int unsigned BYTE_BITS  = 8;

  localparam logic [5:0]  TX_LAST_DATA = 6'h08;
  localparam logic [5:0]  TX_STOP_IDX  = 6'h09;
  localparam logic [5:0]  TX_ACK_IDX   = 6'h0a;

  localparam logic [7:0]  CMD_ENABLE   = 8'hf4;
  localparam int unsigned X_SIGN_POS   = 4;
  localparam int unsigned Y_SIGN_POS   = 5;
  localparam int unsigned BTN_BITS     = 3;
  localparam int unsigned DISP_BITS    = 16;
  localparam int unsigned REPORT_BITS  = SLICES * BYTE_BITS;
  localparam int unsigned FIFO_DEPTH   = 4;
  localparam int unsigned SYNC_BITS    = 4;

  typedef enum logic [2:0] {
    S_IDLE,
    S_INHIBIT,
    S_REQUEST,
    S_TX
  } link_state_e;

endpackage : mouse_link_pkg

// [rtl/pin_sync.sv]
module pin_sync #(
  parameter int unsigned W = 4
) (
  input  wire logic         sys_clk,
  input  wire logic         reset_n,
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } sync_s;

  sync_s r_r;
  sync_s r_nxt;

  always_comb begin
    r_nxt    = r_r;
    r_nxt.s1 = din;
    r_nxt.s2 = r_r.s1;
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      r_r <= '1;
    end else begin
      r_r <= r_nxt;
    end
  end

  assign dout = r_r.s2;

endmodule : pin_sync

// [rtl/report_fifo.sv]
module report_fifo #(
  parameter int unsigned W     = 24,
  parameter int unsigned DEPTH = 4
) (
  input  wire logic         sys_clk,
  input  wire logic         reset_n,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic      [W-1:0] out_data
);

  localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [AW:0] FULL = (AW + 1)'(DEPTH);
  localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW-1:0]           wr;
    logic [AW-1:0]           rd;
    logic [AW:0]             cnt;
  } fifo_s;

  fifo_s r_r;
  fifo_s r_nxt;
  logic  push;
  logic  pop;

  assign in_ready  = (r_r.cnt != FULL);
  assign out_valid = (r_r.cnt != '0);
  assign out_data  = r_r.mem[r_r.rd];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  always_comb begin
    r_nxt = r_r;
    if (push) begin
      r_nxt.mem[r_r.wr] = in_data;
      r_nxt.wr = (r_r.wr == LAST) ? '0 : r_r.wr + 1'b1;
    end
    if (pop) begin
      r_nxt.rd = (r_r.rd == LAST) ? '0 : r_r.rd + 1'b1;
    end
    r_nxt.cnt = r_r.cnt + (AW + 1)'(push) - (AW + 1)'(pop);
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      r_r <= '0;
    end else begin
      r_r <= r_nxt;
    end
  end

endmodule : report_fifo

// [rtl/mouse_host.sv]
module mouse_host
  import mouse_link_pkg::*;
#(
  parameter int unsigned INHIBIT_CYCLES  = INHIBIT_CYC_DEF,
  parameter int unsigned RESPONSE_CYCLES = RESPONSE_CYC_DEF,
  parameter int unsigned RX_GAP_CYCLES   = RX_GAP_CYC_DEF,
  parameter int unsigned DEPTH           = FIFO_DEPTH
) (
  input  wire logic                   sys_clk,
  input  wire logic                   reset_n,
  input  wire logic                   link_clk_in,
  output logic                        link_clk_out,
  output logic                        link_clk_oe_n,
  input  wire logic                   link_data_in,
  output logic                        link_data_out,
  output logic                        link_data_oe_n,
  input  wire logic                   send_btn_n,
  input  wire logic                   clear_btn_n,
  output logic                        report_valid,
  input  wire logic                   report_ready,
  output logic [REPORT_BITS-1:0]      report_data,
  output logic [DISP_BITS-1:0]        x_disp,
  output logic [DISP_BITS-1:0]        y_disp,
  output logic [BTN_BITS-1:0]         buttons,
  output logic                        parity_err,
  output logic                        ack_err,
  output logic                        timeout
);

  typedef struct packed {
    link_state_e            st;
    logic [5:0]             bit_cnt;
    logic [FRAME_BITS-1:0]  shreg;
    logic [8:0]             tx_sh;
    logic [31:0]            timer;
    logic                   skip_ack;
    logic                   check;
    logic                   send_req;
    logic                   pend;
    logic [REPORT_BITS-1:0] frame;
    logic                   clk_drive;
    logic                   data_drive;
    logic                   parity_err;
    logic                   ack_err;
    logic                   timeout;
    logic [DISP_BITS-1:0]   x_acc;
    logic [DISP_BITS-1:0]   y_acc;
    logic [BTN_BITS-1:0]    btn;
    logic                   clk_prev;
    logic                   send_prev;
    logic                   clear_prev;
  } ctl_s;

  ctl_s r_r;
  ctl_s r_nxt;

  logic [SYNC_BITS-1:0]   sync_q;
  logic                   clk_s;
  logic                   data_s;
  logic                   send_s;
  logic                   clear_s;
  logic                   clk_fall;
  logic                   send_press;
  logic                   clear_press;
  logic                   fifo_in_ready;
  logic [SLICES-1:0]      slice_ok;
  logic [REPORT_BITS-1:0] slice_bytes;
  logic [5:0]             rx_last;

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers

  pin_sync #(
    .W (SYNC_BITS)
  ) u_sync (
    .sys_clk (sys_clk),
    .reset_n (reset_n),
    .din     ({link_clk_in, link_data_in, send_btn_n, clear_btn_n}),
    .dout    (sync_q)
  );

  assign {clk_s, data_s, send_s, clear_s} = sync_q;
  assign clk_fall    = r_r.clk_prev & ~clk_s & ~r_r.clk_drive;
  assign send_press  = r_r.send_prev & ~send_s;
  assign clear_press = r_r.clear_prev & ~clear_s;
  assign rx_last     = r_r.skip_ack ? 6'(SLICE_BITS - 1)
                                    : 6'(FRAME_BITS - 1);

  ////////////////////////////////////////////////////////////////////////////
  // Slice checks

  for (genvar k = 0; k < SLICES; k++) begin : g_slice
    localparam int unsigned B = k * SLICE_BITS;
    assign slice_ok[k] = ~r_r.shreg[B + START_POS]
                       & r_r.shreg[B + STOP_POS]
                       & (^r_r.shreg[B + PAR_POS:B + DATA_POS]);
    assign slice_bytes[k*BYTE_BITS +: BYTE_BITS] =
      r_r.shreg[B + DATA_POS +: BYTE_BITS];
  end

  ////////////////////////////////////////////////////////////////////////////
  // Report buffer

  report_fifo #(
    .W     (REPORT_BITS),
    .DEPTH (DEPTH)
  ) u_fifo (
    .sys_clk   (sys_clk),
    .reset_n   (reset_n),
    .in_valid  (r_r.pend),
    .in_ready  (fifo_in_ready),
    .in_data   (r_r.frame),
    .out_valid (report_valid),
    .out_ready (report_ready),
    .out_data  (report_data)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Control

  always_comb begin
    r_nxt            = r_r;
    r_nxt.clk_prev   = clk_s;
    r_nxt.send_prev  = send_s;
    r_nxt.clear_prev = clear_s;
    r_nxt.check      = 1'b0;
    if (send_press) begin
      r_nxt.send_req = 1'b1;
    end
    if (clear_press) begin
      r_nxt.x_acc      = '0;
      r_nxt.y_acc      = '0;
      r_nxt.parity_err = 1'b0;
      r_nxt.ack_err    = 1'b0;
      r_nxt.timeout    = 1'b0;
    end
    if (r_r.pend && fifo_in_ready) begin
      r_nxt.pend = 1'b0;
    end
    if (r_r.check) begin
      if (&slice_ok) begin
        r_nxt.frame = slice_bytes;
        r_nxt.pend  = 1'b1;
        r_nxt.btn   = slice_bytes[BTN_BITS-1:0];
        r_nxt.x_acc = r_nxt.x_acc + {{BYTE_BITS{slice_bytes[X_SIGN_POS]}},
                      slice_bytes[BYTE_BITS +: BYTE_BITS]};
        r_nxt.y_acc = r_nxt.y_acc + {{BYTE_BITS{slice_bytes[Y_SIGN_POS]}},
                      slice_bytes[2*BYTE_BITS +: BYTE_BITS]};
      end else begin
        r_nxt.parity_err = 1'b1;
      end
    end
    unique case (r_r.st)
      S_IDLE: begin
        r_nxt.data_drive = 1'b0;
        r_nxt.clk_drive  = r_nxt.pend & ~fifo_in_ready;
        if (clk_fall) begin
          r_nxt.shreg   = {data_s, r_r.shreg[FRAME_BITS-1:1]};
          r_nxt.timer   = '0;
          r_nxt.bit_cnt = r_r.bit_cnt + 6'h01;
          if (r_r.bit_cnt == rx_last) begin
            r_nxt.bit_cnt  = '0;
            r_nxt.check    = ~r_r.skip_ack;
            r_nxt.skip_ack = 1'b0;
          end
        end else if (r_r.bit_cnt != '0) begin
          r_nxt.timer = r_r.timer + 32'h1;
          if (r_r.timer == 32'(RX_GAP_CYCLES - 1)) begin
            r_nxt.bit_cnt  = '0;
            r_nxt.timer    = '0;
            r_nxt.skip_ack = 1'b0;
          end
        end else if (r_r.send_req && !r_r.pend && !r_r.check) begin
          r_nxt.send_req  = 1'b0;
          r_nxt.st        = S_INHIBIT;
          r_nxt.clk_drive = 1'b1;
          r_nxt.timer     = '0;
          r_nxt.tx_sh     = {~^CMD_ENABLE, CMD_ENABLE};
          r_nxt.skip_ack  = 1'b0;
        end
      end
      S_INHIBIT: begin
        r_nxt.timer = r_r.timer + 32'h1;
        if (r_r.timer == 32'(INHIBIT_CYCLES - 1)) begin
          r_nxt.data_drive = 1'b1;
          r_nxt.st         = S_REQUEST;
          r_nxt.timer      = '0;
        end
      end
      S_REQUEST: begin
        r_nxt.clk_drive = 1'b0;
        r_nxt.st        = S_TX;
        r_nxt.bit_cnt   = '0;
        r_nxt.timer     = '0;
      end
      S_TX: begin
        r_nxt.timer = r_r.timer + 32'h1;
        if (clk_fall) begin
          r_nxt.timer   = '0;
          r_nxt.bit_cnt = r_r.bit_cnt + 6'h01;
          if (r_r.bit_cnt <= TX_LAST_DATA) begin
            r_nxt.data_drive = ~r_r.tx_sh[0];
            r_nxt.tx_sh      = {1'b1, r_r.tx_sh[8:1]};
          end else if (r_r.bit_cnt == TX_STOP_IDX) begin
            r_nxt.data_drive = 1'b0;
          end else begin
            r_nxt.ack_err  = r_nxt.ack_err | data_s;
            r_nxt.skip_ack = ~data_s;
            r_nxt.bit_cnt  = '0;
            r_nxt.st       = S_IDLE;
          end
        end else if (r_r.timer == 32'(RESPONSE_CYCLES - 1)) begin
          r_nxt.timeout    = 1'b1;
          r_nxt.data_drive = 1'b0;
          r_nxt.bit_cnt    = '0;
          r_nxt.timer      = '0;
          r_nxt.st         = S_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      r_r            <= '0;
      r_r.st         <= S_IDLE;
      r_r.clk_prev   <= 1'b1;
      r_r.send_prev  <= 1'b1;
      r_r.clear_prev <= 1'b1;
    end else begin
      r_r <= r_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  assign link_clk_out   = 1'b0;
  assign link_data_out  = 1'b0;
  assign link_clk_oe_n  = ~r_r.clk_drive;
  assign link_data_oe_n = ~r_r.data_drive;
  assign x_disp         = r_r.x_acc;
  assign y_disp         = r_r.y_acc;
  assign buttons        = r_r.btn;
  assign parity_err     = r_r.parity_err;
  assign ack_err        = r_r.ack_err;
  assign timeout        = r_r.timeout;

  ////////////////////////////////////////////////////////////////////////////
  // Assertions

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);

  inhibit_length_a: assert property (
    $rose(r_r.st == S_REQUEST) |->
      $past(r_r.st) == S_INHIBIT && $past(r_r.clk_drive) &&
      $past(r_r.timer) == 32'(INHIBIT_CYCLES - 1))
    else $error("request entered before inhibit time");

  request_order_a: assert property (
    r_r.st == S_REQUEST |->
      !link_data_oe_n && !link_clk_oe_n ##1 link_clk_oe_n && !link_data_oe_n)
    else $error("request sequence out of order");

  parity_release_a: assert property (
    r_r.st == S_TX && clk_fall && r_r.bit_cnt == TX_STOP_IDX |=>
      link_data_oe_n)
    else $error("data still driven after parity");

  rx_sample_a: assert property (
    r_r.st == S_IDLE && clk_fall |=>
      r_r.shreg[FRAME_BITS-1] == $past(data_s))
    else $error("data not sampled on clock fall");

  frame_length_a: assert property (
    r_r.st == S_IDLE && clk_fall && !r_r.skip_ack &&
    r_r.bit_cnt == 6'(FRAME_BITS - 1) |=> r_r.check && r_r.bit_cnt == '0)
    else $error("frame not closed after 33 bits");

  parity_flag_a: assert property (
    r_r.check && !(&slice_ok) |=> parity_err)
    else $error("bad slice not flagged");

  ack_flag_a: assert property (
    r_r.st == S_TX && clk_fall && r_r.bit_cnt == TX_ACK_IDX && data_s
    |=> ack_err && r_r.st == S_IDLE)
    else $error("missing acknowledge not flagged");

  response_timeout_a: assert property (
    r_r.st == S_TX && !clk_fall &&
    r_r.timer == 32'(RESPONSE_CYCLES - 1) |=>
      timeout && r_r.st == S_IDLE && link_clk_oe_n && link_data_oe_n)
    else $error("send not abandoned on timeout");

  full_hold_a: assert property (
    r_r.st == S_IDLE && r_r.pend && !fifo_in_ready && !r_r.check |=>
      !link_clk_oe_n)
    else $error("clock not held while buffer full");

  clear_disp_a: assert property (
    clear_press && !r_r.check |=> x_disp == '0 && y_disp == '0)
    else $error("displacement not cleared");

  send_start_a: assert property (
    r_r.st == S_IDLE && r_r.send_req && !r_r.pend && !r_r.check &&
    !clk_fall && r_r.bit_cnt == '0 |=> r_r.st == S_INHIBIT)
    else $error("send request not started");

  frame_cover_c: cover property (r_r.check && (&slice_ok));
  send_cover_c: cover property (
    r_r.st == S_TX && clk_fall && r_r.bit_cnt == TX_ACK_IDX && !data_s);
  timeout_cover_c: cover property ($rose(r_r.timeout));
  full_cover_c: cover property (r_r.pend && !fifo_in_ready);

endmodule : mouse_host

// [verif/mouse_model.sv]
module mouse_model (
  input  wire logic clk_line,
  input  wire logic data_line,
  input  wire logic no_ack,
  input  wire logic mute,
  input  wire logic bad_par,
  output logic      clk_oe_n,
  output logic      data_oe_n
);
  timeunit 1ns;
  timeprecision 100ps;

  logic       enabled;
  logic [7:0] rx_byte;
  logic       rx_stop;
  logic       rx_par_ok;

  initial begin
    clk_oe_n  = 1'b1;
    data_oe_n = 1'b1;
    enabled   = 1'b0;
  end

  ////////////////////////////////////////
  // Outgoing slice, clock made here as well as in host_rx
  task automatic send_slice(input logic [7:0] d, input logic bp);
    logic [10:0] f;
    f = {1'b1, ~^d ^ bp, d, 1'b0};
    wait (clk_line === 1'b1);
    for (int i = 0; i < 11; i++) begin
      data_oe_n = f[i];
      #12;
      clk_oe_n = 1'b0;
      #24;
      clk_oe_n = 1'b1;
      #12;
    end
    data_oe_n = 1'b1;
  endtask : send_slice

  task automatic send_report(input logic [7:0] st, input logic [7:0] x,
                             input logic [7:0] y);
    if (enabled) begin
      send_slice(st, bad_par);
      #60;
      send_slice(x, 1'b0);
      #60;
      send_slice(y, 1'b0);
      #300;
    end
  endtask : send_report

  // Host byte after a request
  task automatic host_rx();
    logic [9:0] b;
    logic       ack;
    #30;
    for (int k = 0; k < 10; k++) begin
      clk_oe_n = 1'b0;
      #24;
      clk_oe_n = 1'b1;
      b[k] = data_line;
      #24;
    end
    ack = !no_ack && b[9];
    if (ack) begin
      data_oe_n = 1'b0;
    end
    clk_oe_n = 1'b0;
    #24;
    clk_oe_n = 1'b1;
    #24;
    data_oe_n = 1'b1;
    rx_byte   = b[7:0];
    rx_stop   = b[9];
    rx_par_ok = ^b[8:0];
    if (ack && b[7:0] == 8'hf4) begin
      enabled = 1'b1;
      #200;
      send_slice(8'hfa, 1'b0);
    end
  endtask : host_rx

  always begin
    @(negedge clk_line);
    if (clk_oe_n) begin
      wait (clk_line === 1'b1);
      if (data_line === 1'b0 && !mute) begin
        host_rx();
      end
    end
  end
endmodule : mouse_model

// [verif/mouse_host_test.sv]
module mouse_host_test
  import mouse_link_pkg::*;
();
  timeunit 1ns;
  timeprecision 100ps;

  logic                   sys_clk, reset_n, send_btn_n, clear_btn_n;
  logic                   report_ready, report_valid, no_ack, mute, bad_par;
  logic                   h_clk_oe_n, h_data_oe_n, m_clk_oe_n, m_data_oe_n;
  logic                   h_clk_out, h_data_out;
  logic                   parity_err, ack_err, timeout;
  logic [REPORT_BITS-1:0] report_data;
  logic [DISP_BITS-1:0]   x_disp, y_disp, ex, ey;
  logic [BTN_BITS-1:0]    buttons;
  wire logic              clk_line;
  wire logic              data_line;
  int                     err_count = 0;
  int                     num_checks = 0;
  int                     cyc = 0;
  int                     inh = 0;

  // Open-drain lines with pull-up
  assign clk_line  = h_clk_oe_n & m_clk_oe_n;
  assign data_line = h_data_oe_n & m_data_oe_n;

  mouse_host #(
    .INHIBIT_CYCLES (20),
    .RESPONSE_CYCLES(400),
    .RX_GAP_CYCLES  (200)
  ) i_mouse_host (
    .sys_clk(sys_clk), .reset_n(reset_n), .link_clk_in(clk_line),
    .link_clk_out(h_clk_out), .link_clk_oe_n(h_clk_oe_n),
    .link_data_in(data_line), .link_data_out(h_data_out),
    .link_data_oe_n(h_data_oe_n),
    .send_btn_n(send_btn_n), .clear_btn_n(clear_btn_n),
    .report_valid(report_valid), .report_ready(report_ready),
    .report_data(report_data), .x_disp(x_disp), .y_disp(y_disp),
    .buttons(buttons), .parity_err(parity_err), .ack_err(ack_err),
    .timeout(timeout)
  );

  mouse_model i_mouse_model (
    .clk_line(clk_line), .data_line(data_line), .no_ack(no_ack),
    .mute(mute), .bad_par(bad_par), .clk_oe_n(m_clk_oe_n),
    .data_oe_n(m_data_oe_n)
  );

  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end

  always @(negedge sys_clk) begin
    if (!h_clk_oe_n && h_data_oe_n) begin
      inh++;
    end
  end

  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 30000) begin
      err_count++;
      wrap_up();
    end
  end

  ////////////////////////////////////////
  task automatic wrap_up();
    $display("checks %0d errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : wrap_up

  task automatic chk_bit(string n, logic e, logic g);
    num_checks++;
    if (g !== e) begin
      err_count++;
      $display("unexpected %s: expected %b seen %b", n, e, g);
    end
  endtask : chk_bit

  task automatic chk_val(string n, logic [23:0] e, logic [23:0] g);
    num_checks++;
    if (g !== e) begin
      err_count++;
      $display("unexpected %s: expected %h seen %h", n, e, g);
    end
  endtask : chk_val

  task automatic press(logic clr);
    @(negedge sys_clk);
    send_btn_n  = clr;
    clear_btn_n = !clr;
    repeat (4) @(negedge sys_clk);
    send_btn_n  = 1'b1;
    clear_btn_n = 1'b1;
  endtask : press

  task automatic t_enable();
    chk_bit("clk_oe_n", 1'b1, h_clk_oe_n);
    chk_bit("data_oe_n", 1'b1, h_data_oe_n);
    inh = 0;
    press(1'b0);
    for (int i = 0; i < 100 && h_data_oe_n !== 1'b0; i++) @(negedge sys_clk);
    chk_bit("inhibit", 1'b1, inh >= 20);
    repeat (2) @(negedge sys_clk);
    chk_bit("req clk", 1'b1, h_clk_oe_n);
    chk_bit("req data", 1'b0, h_data_oe_n);
    chk_bit("clk_out", 1'b0, h_clk_out);
    chk_bit("data_out", 1'b0, h_data_out);
    for (int i = 0; i < 600 && !i_mouse_model.enabled; i++) @(negedge sys_clk);
    repeat (300) @(negedge sys_clk);
    chk_val("cmd", 24'hf4, {16'h0, i_mouse_model.rx_byte});
    chk_bit("cmd parity", 1'b1, i_mouse_model.rx_par_ok);
    chk_bit("stop", 1'b1, i_mouse_model.rx_stop);
    chk_bit("ack_err", 1'b0, ack_err);
    chk_bit("ack slice", 1'b0, report_valid);
  endtask : t_enable

  task automatic t_reports();
    logic [7:0] st [5] = '{8'h09, 8'h1a, 8'h2c, 8'h3f, 8'h0d};
    logic [7:0] xv [5] = '{8'h05, 8'hfb, 8'h80, 8'h7f, 8'h00};
    logic [7:0] yv [5] = '{8'h01, 8'h40, 8'hfe, 8'h81, 8'hff};
    for (int i = 0; i < 5; i++) begin
      i_mouse_model.send_report(st[i], xv[i], yv[i]);
      ex += {{8{st[i][4]}}, xv[i]};
      ey += {{8{st[i][5]}}, yv[i]};
    end
    repeat (20) @(negedge sys_clk);
    chk_bit("hold clk", 1'b0, h_clk_oe_n);
    chk_val("x", {8'h0, ex}, {8'h0, x_disp});
    chk_val("y", {8'h0, ey}, {8'h0, y_disp});
    chk_val("buttons", {21'h0, st[4][2:0]}, {21'h0, buttons});
    for (int i = 0; i < 5; i++) begin
      for (int j = 0; j < 50 && report_valid !== 1'b1; j++) begin
        @(negedge sys_clk);
      end
      chk_bit("valid", 1'b1, report_valid);
      chk_val("report", {yv[i], xv[i], st[i]}, report_data);
      report_ready = 1'b1;
      @(negedge sys_clk);
      report_ready = 1'b0;
    end
    repeat (5) @(negedge sys_clk);
    chk_bit("empty", 1'b0, report_valid);
    chk_bit("free clk", 1'b1, h_clk_oe_n);
  endtask : t_reports

  task automatic t_errors();
    bad_par = 1'b1;
    i_mouse_model.send_report(8'h08, 8'h11, 8'h22);
    bad_par = 1'b0;
    repeat (20) @(negedge sys_clk);
    chk_bit("parity_err", 1'b1, parity_err);
    chk_bit("dropped", 1'b0, report_valid);
    chk_val("x kept", {8'h0, ex}, {8'h0, x_disp});
    no_ack = 1'b1;
    press(1'b0);
    for (int i = 0; i < 800 && ack_err !== 1'b1; i++) @(negedge sys_clk);
    chk_bit("ack_err", 1'b1, ack_err);
    no_ack = 1'b0;
    press(1'b1);
    repeat (5) @(negedge sys_clk);
    chk_bit("cleared", 1'b0, parity_err | ack_err);
    chk_val("x clr", 24'h0, {8'h0, x_disp});
    chk_val("y clr", 24'h0, {8'h0, y_disp});
    mute = 1'b1;
    press(1'b0);
    for (int i = 0; i < 800 && timeout !== 1'b1; i++) @(negedge sys_clk);
    chk_bit("timeout", 1'b1, timeout);
    chk_bit("rel clk", 1'b1, h_clk_oe_n);
    chk_bit("rel data", 1'b1, h_data_oe_n);
    mute = 1'b0;
  endtask : t_errors

  initial begin
    reset_n      = 1'b0;
    send_btn_n   = 1'b1;
    clear_btn_n  = 1'b1;
    report_ready = 1'b0;
    no_ack       = 1'b0;
    mute         = 1'b0;
    bad_par      = 1'b0;
    ex           = '0;
    ey           = '0;
    repeat (3) @(negedge sys_clk);
    reset_n = 1'b1;
    repeat (3) @(negedge sys_clk);
    chk_bit("valid rst", 1'b0, report_valid);
    t_enable();
    t_reports();
    t_errors();
    wrap_up();
  end
endmodule : mouse_host_test
